// ==== design/pss_defs.svh ====
/*
 * Constants of the playback status sequencer: register offsets, field
 * positions, reset values and timing figures.
 * Assumes a 100 MHz core clock and a 32-bit APB with byte addresses.
 */
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH

// register byte offsets
`define REG_CTRL        8'h00
`define REG_DEBOUNCE    8'h04
`define REG_AMP_LEAD    8'h08
`define REG_AMP_HOLD    8'h0C
`define REG_STATE       8'h10
`define REG_PAD_COUNT   8'h14

// control register bits
`define CTRL_STANDALONE 0
`define CTRL_FLASH      1
`define CTRL_FAST       2
`define CTRL_ERR_CLR    3

// state register bits
`define ST_STATUS       0
`define ST_ERROR        1
`define ST_MSG_READY    2
`define ST_AMP_ON       3
`define ST_AWAKE        4
`define ST_PINS_EN      5
`define ST_PLAY_LSB     8
`define ST_SLEEP_LSB    12

// reset values
`define CTRL_RST        4'h0
`define DEBOUNCE_RST    8'h01
`define AMP_LEAD_RST    8'h01
`define AMP_HOLD_RST    16'h0001

// timing
`define CLK_NS          10
`define T_US_NS         1000
`define US_CYC          (`T_US_NS / `CLK_NS)
`define MS_US           1000
`define T_BOOT_MS       50
`define T_MSG_GAP_US    1000
`define T_MSG_OVR_US    120000
`define T_PIN_GUARD_MS  2
`define T_FLASH_TO_MS   20000
`define AMP_UNIT_MS     10
`define T_WAKE_DEEP_US_A 550
`define T_WAKE_DEEP_US_B 200
`define T_WAKE_PIN_US_A 510
`define T_WAKE_PIN_US_B 170
`define T_WAKE_LIGHT_US_A 50
`define T_WAKE_LIGHT_US_B 40

`endif

// ==== design/pss_pkg.sv ====
/*
 * Types of the playback status sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package pss_pkg;
	typedef enum logic [1:0] {P_IDLE, P_LEAD, P_PLAY, P_HOLD} play_st_t;
	typedef enum logic [1:0] {S_ACTIVE, S_SLEEP, S_DEEP, S_WAKE} sleep_st_t;

	// activity levels and the init completion flag reported by the sound core
	typedef struct packed {
		logic rec_active;
		logic tone_active;
		logic mem_check;
		logic self_check;
		logic init_done;
	} core_evt_t;

	typedef struct packed {
		logic       s1;
		logic       s2;
		logic       s3;
		logic [7:0] cnt;
		logic       valid;
		logic       chg;
	} deb_st_t;

	typedef struct packed {
		logic [7:0]  us_div;
		logic [9:0]  ms_div;
		logic        us_tick;
		logic        ms_tick;
		logic        booting;
		logic [5:0]  boot_cnt;
		logic        msg_ready;
		logic [16:0] msg_gap;
		logic        byte_accept;
		logic [15:0] pad_cnt;
		logic        pins_en;
		logic [1:0]  pin_guard;
		logic [7:0]  pin_prev;
		logic [7:0]  pin_event;
		play_st_t    pst;
		logic [19:0] amp_cnt;
		logic        amp_on;
		logic        amp_oe;
		logic        play_start;
		logic        flash_busy;
		logic [14:0] flash_cnt;
		logic        fail_pend;
		logic        error;
		logic        status;
		sleep_st_t   sst;
		logic        awake;
		logic [9:0]  wake_cnt;
		logic [3:0]  ctrl;
		logic [7:0]  deb_cfg;
		logic [7:0]  lead_cfg;
		logic [15:0] hold_cfg;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} seq_st_t;
endpackage : pss_pkg
`default_nettype wire

// ==== design/pin_debouncer.sv ====
/*
 * One control pin: three-stage synchroniser and stability filter that
 * counts sampling ticks.
 * Assumes sample_tick is a one-cycle pulse on core_clk.
 */
`include "pss_defs.svh"
`default_nettype none
module pin_debouncer import pss_pkg::*; (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic       sample_tick,
	input  wire logic       pin_raw,
	input  wire logic [7:0] stable_ticks,
	output logic            valid_o,
	output logic            change_o,
	output logic            sync_o
);
	deb_st_t    s_r;
	deb_st_t    s_nxt;
	logic [7:0] need;

	assign need = (stable_ticks == 8'h00) ? 8'h01 : stable_ticks;

	always_comb begin
		s_nxt     = s_r;
		s_nxt.s1  = pin_raw;
		s_nxt.s2  = s_r.s1;
		s_nxt.s3  = s_r.s2;
		s_nxt.chg = 1'b0;
		if (sample_tick) begin // R5
			if (s_r.s2 == s_r.s3 && s_r.s3 != s_r.valid) begin
				if ({1'b0, s_r.cnt} + 9'h001 >= {1'b0, need}) begin // R6
					s_nxt.valid = s_r.s3;
					s_nxt.chg   = 1'b1;
					s_nxt.cnt   = 8'h00;
				end else begin
					s_nxt.cnt = s_r.cnt + 8'h01;
				end
			end else begin
				s_nxt.cnt = 8'h00;
			end
		end
	end

	// pins idle high through pull-ups
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, cnt: 8'h00, valid: 1'b1, chg: 1'b0};
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign valid_o  = s_r.valid;
	assign change_o = s_r.chg;
	assign sync_o   = s_r.s3;

	a_deb_change: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clk_en && !sample_tick) |=> !change_o)
		else $error("pin change outside a sampling tick"); // R5
endmodule : pin_debouncer
`default_nettype wire

// ==== design/playback_status_sequencer.sv ====
/*
 * Playback status sequencer: status and error outputs, message gating,
 * standalone pin filtering, sleep wake-up timing and amplifier enable.
 * Assumes a 100 MHz core_clk, an APB master, and event pulses from the
 * sound core on the same clock; control pins arrive asynchronously.
 */
`include "pss_defs.svh"
`default_nettype none
// Summary of operation
// R1: status high during boot and any activity
// R2: message reception enabled within 50 ms
// R3: playback starts within 60 ms of status
// R4: status updated within 6 ms after playback
// R5: pins sampled on a 1 ms tick
// R6: pin valid after 1 to 255 stable ticks
// R7: pin detection enabled within 50 ms
// R8: next pin operation ready 1 to 3 ms
// R9: next message accepted within 1 ms
// R10: overwrite message may need up to 120 ms
// R11: padding bytes while not ready are discarded
// R12: flash mode status rises within 70 us
// R13: error rises within 40 us after status falls
// R14: flash access times out after 20 s
// R15: host deep-sleep wake within 550/200 us
// R16: pin deep-sleep wake within 510/170 us
// R17: host light-sleep wake within 50/40 us
// R18: amplifier lead 10 to 2550 ms
// R19: amplifier hold 10 to 655350 ms
// R20: replay in hold restarts, skips lead
// R21: pins ignored during amplifier lead
// R22: amplifier pin undriven until first activation
module playback_status_sequencer import pss_pkg::*; #(
	parameter int          N_PINS      = 4,
	parameter logic [7:0]  US_CYC      = 8'(`US_CYC),
	parameter logic [9:0]  MS_US       = 10'(`MS_US),
	parameter logic [5:0]  BOOT_MS     = 6'(`T_BOOT_MS),
	parameter logic [14:0] FLASH_TO_MS = 15'(`T_FLASH_TO_MS)
) (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic              clk_en,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire core_evt_t         core_evt,
	input  wire logic              msg_rx,
	input  wire logic              msg_overwrite,
	input  wire logic              byte_rx,
	input  wire logic              play_req,
	input  wire logic              play_done,
	input  wire logic              flash_done,
	input  wire logic              flash_fail,
	input  wire logic              sleep_request_message,
	input  wire logic              sleep_deep,
	input  wire logic              wake_request_message,
	input  wire logic [N_PINS-1:0] ctrl_pin,
	output logic                   status_out,
	output logic                   error_out,
	output logic                   msg_ready,
	output logic                   byte_accept,
	output logic      [N_PINS-1:0] pin_event,
	output logic      [N_PINS-1:0] pin_level,
	output logic                   play_start,
	output logic                   awake,
	output logic                   external_amp_enable,
	output logic                   external_amp_enable_oe
);
	seq_st_t           s;
	seq_st_t           n;
	logic [N_PINS-1:0] deb_chg;
	logic [N_PINS-1:0] pin_sync;
	logic              standalone;
	logic              fast;
	logic              activity;
	logic              pin_fall;

	function automatic logic [19:0] amp_ms(input logic [15:0] units);
		logic [15:0] u;
		u = (units == 16'h0000) ? 16'h0001 : units;
		amp_ms = 20'({4'h0, u}) * 20'(`AMP_UNIT_MS);
	endfunction : amp_ms

	genvar gi;
	generate
		for (gi = 0; gi < N_PINS; gi++) begin : g_pin
			pin_debouncer u_deb (
				.core_clk     (core_clk),
				.rst_n        (rst_n),
				.clk_en       (clk_en),
				.sample_tick  (s.ms_tick),
				.pin_raw      (ctrl_pin[gi]),
				.stable_ticks (s.deb_cfg),
				.valid_o      (pin_level[gi]),
				.change_o     (deb_chg[gi]),
				.sync_o       (pin_sync[gi])
			);
		end
	endgenerate

	assign standalone = s.ctrl[`CTRL_STANDALONE];
	assign fast       = s.ctrl[`CTRL_FAST];
	assign pin_fall   = |(s.pin_prev[N_PINS-1:0] & ~pin_sync);
	assign activity   = core_evt.rec_active | core_evt.tone_active | core_evt.mem_check
		| core_evt.self_check;

	always_comb begin
		n             = s;
		n.us_tick     = 1'b0;
		n.ms_tick     = 1'b0;
		n.byte_accept = 1'b0;
		n.play_start  = 1'b0;
		n.pin_event   = 8'h00;
		n.pready      = 1'b0;
		n.pslverr     = 1'b0;
		n.pin_prev    = 8'(pin_sync);

		// time base: tick derived from core_clk, so it shares its error
		if (s.us_div >= US_CYC - 8'h01) begin
			n.us_div  = 8'h00;
			n.us_tick = 1'b1;
			if (s.ms_div >= MS_US - 10'h001) begin
				n.ms_div  = 10'h000;
				n.ms_tick = 1'b1; // R5
			end else begin
				n.ms_div = s.ms_div + 10'h001;
			end
		end else begin
			n.us_div = s.us_div + 8'h01;
		end

		// register bus; software clears come first so hardware sets win
		if (psel && !penable && !s.pready) begin
			n.pready = 1'b1;
			n.prdata = 32'h0000_0000;
			case (paddr)
				`REG_CTRL:      n.prdata = {28'h0, s.ctrl};
				`REG_DEBOUNCE:  n.prdata = {24'h0, s.deb_cfg};
				`REG_AMP_LEAD:  n.prdata = {24'h0, s.lead_cfg};
				`REG_AMP_HOLD:  n.prdata = {16'h0, s.hold_cfg};
				`REG_PAD_COUNT: n.prdata = {16'h0, s.pad_cnt};
				`REG_STATE: begin
					n.prdata[`ST_STATUS]    = s.status;
					n.prdata[`ST_ERROR]     = s.error;
					n.prdata[`ST_MSG_READY] = s.msg_ready;
					n.prdata[`ST_AMP_ON]    = s.amp_on;
					n.prdata[`ST_AWAKE]     = (s.sst == S_ACTIVE);
					n.prdata[`ST_PINS_EN]   = s.pins_en;
					n.prdata[`ST_PLAY_LSB+:2]  = s.pst;
					n.prdata[`ST_SLEEP_LSB+:2] = s.sst;
				end
				default: n.pslverr = 1'b1;
			endcase
		end
		if (psel && penable && s.pready && pwrite) begin
			case (paddr)
				`REG_CTRL: begin
					n.ctrl = pwdata[3:0] & 4'h7;
					if (pwdata[`CTRL_ERR_CLR]) begin
						n.error = 1'b0;
					end
				end
				`REG_DEBOUNCE:  n.deb_cfg  = pwdata[7:0];
				`REG_AMP_LEAD:  n.lead_cfg = pwdata[7:0];
				`REG_AMP_HOLD:  n.hold_cfg = pwdata[15:0];
				`REG_PAD_COUNT: n.pad_cnt  = 16'h0000;
				default: ;
			endcase
		end

		// boot: core init or the 50 ms ceiling, whichever comes first
		if (s.booting) begin
			if (core_evt.init_done || (s.ms_tick && s.boot_cnt >= BOOT_MS - 6'h01)) begin
				n.booting   = 1'b0; // R2
				n.msg_ready = 1'b1;
			end else if (s.ms_tick) begin
				n.boot_cnt = s.boot_cnt + 6'h01;
			end
		end
		n.pins_en = !s.booting && !core_evt.self_check && standalone; // R7

		// message gating
		if (s.msg_ready && msg_rx) begin
			n.msg_ready = 1'b0; // R9
			n.msg_gap   = msg_overwrite ? 17'(`T_MSG_OVR_US - 1)
				: 17'(`T_MSG_GAP_US - 1); // R10
			if (s.ctrl[`CTRL_FLASH]) begin
				n.flash_busy = 1'b1; // R12
				n.flash_cnt  = 15'h0000;
			end
		end else if (!s.msg_ready && !s.booting && s.us_tick) begin
			if (s.msg_gap == 17'h00000) begin
				n.msg_ready = 1'b1;
			end else begin
				n.msg_gap = s.msg_gap - 17'h00001;
			end
		end
		if (byte_rx) begin
			if (s.msg_ready) begin
				n.byte_accept = 1'b1;
			end else begin
				n.pad_cnt = n.pad_cnt + 16'h0001; // R11
			end
		end

		// flash access and failure report
		if (s.flash_busy) begin
			if (flash_done) begin
				n.flash_busy = 1'b0;
				n.fail_pend  = flash_fail;
			end else if (s.ms_tick) begin
				if (s.flash_cnt >= FLASH_TO_MS - 15'h0001) begin
					n.flash_busy = 1'b0; // R14
					n.fail_pend  = 1'b1;
				end else begin
					n.flash_cnt = s.flash_cnt + 15'h0001;
				end
			end
		end
		if (s.fail_pend && !s.status) begin
			n.fail_pend = 1'b0;
			n.error     = 1'b1; // R13
		end

		// standalone pins: blocked during lead, sleep and the post-event guard
		if (s.pin_guard != 2'h0 && s.ms_tick) begin
			n.pin_guard = s.pin_guard - 2'h1;
		end
		if (s.pins_en && s.pin_guard == 2'h0 && s.pst != P_LEAD && s.sst == S_ACTIVE
			&& |deb_chg) begin // R21
			n.pin_event = 8'(deb_chg);
			n.pin_guard = 2'(`T_PIN_GUARD_MS); // R8
		end

		// playback and amplifier enable
		case (s.pst)
			P_IDLE: begin
				if (play_req) begin
					if (standalone && !s.amp_on) begin
						n.pst     = P_LEAD;
						n.amp_on  = 1'b1; // R18
						n.amp_oe  = 1'b1; // R22
						n.amp_cnt = amp_ms({8'h00, s.lead_cfg});
					end else begin
						n.pst        = P_PLAY; // R3
						n.play_start = 1'b1;
					end
				end
			end
			P_LEAD: begin
				if (s.ms_tick) begin
					if (s.amp_cnt == 20'h00000) begin
						n.pst        = P_PLAY; // R18
						n.play_start = 1'b1;
					end else begin
						n.amp_cnt = s.amp_cnt - 20'h00001;
					end
				end
			end
			P_PLAY: begin
				if (play_done) begin
					n.pst = s.amp_on ? P_HOLD : P_IDLE; // R4
					n.amp_cnt = amp_ms(s.hold_cfg);
				end
			end
			P_HOLD: begin
				if (play_req) begin
					n.pst        = P_PLAY; // R20
					n.play_start = 1'b1;
				end else if (s.ms_tick) begin
					if (s.amp_cnt == 20'h00000) begin
						n.pst    = P_IDLE; // R19
						n.amp_on = 1'b0;
					end else begin
						n.amp_cnt = s.amp_cnt - 20'h00001;
					end
				end
			end
			default: n.pst = P_IDLE;
		endcase

		// sleep and wake-up; counts stop one tick short so phase never overshoots
		case (s.sst)
			S_ACTIVE: begin
				if (sleep_request_message && !s.booting) begin
					n.sst = sleep_deep ? S_DEEP : S_SLEEP;
				end
			end
			S_SLEEP: begin
				if (wake_request_message) begin
					n.sst      = S_WAKE; // R17
					n.wake_cnt = fast ? 10'(`T_WAKE_LIGHT_US_B - 1) : 10'(`T_WAKE_LIGHT_US_A - 1);
				end
			end
			S_DEEP: begin
				if (wake_request_message && !standalone) begin
					n.sst      = S_WAKE; // R15
					n.wake_cnt = fast ? 10'(`T_WAKE_DEEP_US_B - 1) : 10'(`T_WAKE_DEEP_US_A - 1);
				end else if (pin_fall && standalone) begin
					n.sst      = S_WAKE; // R16
					n.wake_cnt = fast ? 10'(`T_WAKE_PIN_US_B - 1) : 10'(`T_WAKE_PIN_US_A - 1);
				end
			end
			S_WAKE: begin
				if (s.us_tick) begin
					if (s.wake_cnt == 10'h000) begin
						n.sst = S_ACTIVE;
					end else begin
						n.wake_cnt = s.wake_cnt - 10'h001;
					end
				end
			end
			default: n.sst = S_ACTIVE;
		endcase
		n.awake = (n.sst == S_ACTIVE);

		n.status = n.booting || n.pst == P_PLAY || n.flash_busy || activity; // R1
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s          <= '0;
			s.booting  <= 1'b1;
			s.status   <= 1'b1;
			s.awake    <= 1'b1;
			s.pin_prev <= 8'hFF;
			s.ctrl     <= `CTRL_RST;
			s.deb_cfg  <= `DEBOUNCE_RST;
			s.lead_cfg <= `AMP_LEAD_RST;
			s.hold_cfg <= `AMP_HOLD_RST;
		end else if (clk_en) begin
			s <= n;
		end
	end

	assign prdata                 = s.prdata;
	assign pready                 = s.pready;
	assign pslverr                = s.pslverr;
	assign status_out             = s.status;
	assign error_out              = s.error;
	assign msg_ready              = s.msg_ready;
	assign byte_accept            = s.byte_accept;
	assign pin_event              = s.pin_event[N_PINS-1:0];
	assign play_start             = s.play_start;
	assign awake                  = s.awake;
	assign external_amp_enable    = s.amp_on;
	assign external_amp_enable_oe = s.amp_oe;

	a_boot_status: assert property (@(posedge core_clk) disable iff (!rst_n)
		s.booting |-> status_out && !msg_ready)
		else $error("status low or messages open during boot"); // R1
	a_boot_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
		s.booting |-> s.boot_cnt < BOOT_MS)
		else $error("boot exceeded its ceiling"); // R2
	a_play_status: assert property (@(posedge core_clk) disable iff (!rst_n)
		play_start |-> status_out)
		else $error("playback started with status low"); // R3
	a_play_end: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clk_en && s.pst == P_PLAY && play_done && !activity && !s.flash_busy
		&& !s.booting) |=> !status_out)
		else $error("status not updated after playback end"); // R4
	a_msg_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clk_en && msg_rx && msg_ready) |=> !msg_ready)
		else $error("message window not closed after a message"); // R9
	a_pad_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clk_en && byte_rx && !msg_ready) |=> !byte_accept)
		else $error("padding byte accepted"); // R11
	a_flash_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clk_en && msg_rx && msg_ready && s.ctrl[`CTRL_FLASH]) |=> status_out)
		else $error("status not raised for flash message"); // R12
	a_err_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clk_en && s.fail_pend && !status_out) |=> error_out)
		else $error("error not raised after status fell"); // R13
	a_lead_pins: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clk_en && s.pst == P_LEAD) |=> pin_event == '0)
		else $error("pin event during amplifier lead"); // R21
	a_hold_replay: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clk_en && s.pst == P_HOLD && play_req) |=> play_start && external_amp_enable)
		else $error("replay in hold did not start at once"); // R20
	a_amp_float: assert property (@(posedge core_clk) disable iff (!rst_n)
		external_amp_enable |-> external_amp_enable_oe)
		else $error("amplifier enable high while undriven"); // R22
endmodule : playback_status_sequencer
`default_nettype wire

// ==== verification/host_model.sv ====
/*
 * Host side model: sends whole messages and padding bytes.
 * Assumes every pulse is sampled on the rising edge of core_clk.
 */
`default_nettype none
module host_model (
	input  wire logic core_clk,
	input  wire logic msg_ready,
	output logic      msg_rx,
	output logic      msg_overwrite,
	output logic      byte_rx
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		msg_rx = 1'b0;
		msg_overwrite = 1'b0;
		byte_rx = 1'b0;
	end
	// never pushes a message at a busy device; n counts the wait
	task send_msg(input logic ovr, output int n);
		n = 0;
		@(posedge core_clk);
		while (msg_ready !== 1'b1) begin
			@(posedge core_clk);
			n++;
		end
		msg_rx <= 1'b1;
		msg_overwrite <= ovr;
		@(posedge core_clk) msg_rx <= 1'b0;
		msg_overwrite <= 1'b0;
	endtask : send_msg
	task send_pad(input int k);
		repeat (k) begin
			@(posedge core_clk) byte_rx <= 1'b1;
			@(posedge core_clk) byte_rx <= 1'b0;
		end
	endtask : send_pad
endmodule : host_model
`default_nettype wire

// ==== verification/playback_status_sequencer_tb_top.sv ====
/*
 * Self-checking bench of the playback status sequencer with a host model.
 * Assumes shortened tick parameters: 2 cycles a us tick, 8 cycles a ms tick.
 */
`default_nettype none
module playback_status_sequencer_tb_top import pss_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MS = 8;
	logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	core_evt_t   core_evt;
	logic        msg_rx, msg_ovr, byte_rx, play_req, play_done, flash_done, flash_fail;
	logic        slp_req, sleep_deep, wake_req, status_out, error_out, msg_ready;
	logic        byte_accept, play_start, awake, amp_en, amp_oe, lvl0, clk_en;
	logic [3:0]  ctrl_pin, pin_event, pin_level;
	int          miscompares = 0, checked = 0, n, acc_cnt = 0, ev_cnt = 0;
	assign lvl0 = pin_level[0];

	playback_status_sequencer #(.US_CYC(8'h02), .MS_US(10'h004), .BOOT_MS(6'h03),
		.FLASH_TO_MS(15'h0005)) uut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .core_evt(core_evt),
		.msg_rx(msg_rx), .msg_overwrite(msg_ovr), .byte_rx(byte_rx), .play_req(play_req),
		.play_done(play_done), .flash_done(flash_done), .flash_fail(flash_fail),
		.sleep_request_message(slp_req), .sleep_deep(sleep_deep),
		.wake_request_message(wake_req), .ctrl_pin(ctrl_pin), .status_out(status_out),
		.error_out(error_out), .msg_ready(msg_ready), .byte_accept(byte_accept),
		.pin_event(pin_event), .pin_level(pin_level), .play_start(play_start),
		.awake(awake), .external_amp_enable(amp_en), .external_amp_enable_oe(amp_oe));
	host_model host (.core_clk(core_clk), .msg_ready(msg_ready), .msg_rx(msg_rx),
		.msg_overwrite(msg_ovr), .byte_rx(byte_rx));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (byte_accept === 1'b1) acc_cnt++;
		if (pin_event !== 4'h0) ev_cnt++;
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic wt(ref logic s, input logic v, input string nm, input int lo, input int hi);
		n = 0;
		while (s !== v && n <= hi) begin
			@(posedge core_clk);
			n++;
		end
		checked++;
		if (n < lo || n > hi) begin
			miscompares++;
			$display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, n);
		end
	endtask : wt
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk) penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task pulse(input int w);
		@(posedge core_clk);
		case (w)
			0: play_req <= 1'b1;
			1: play_done <= 1'b1;
			2: slp_req <= 1'b1;
			3: wake_req <= 1'b1;
			default: flash_done <= 1'b1;
		endcase
		@(posedge core_clk);
		{play_req, play_done, slp_req, wake_req, flash_done} <= 5'h00;
	endtask : pulse
	task do_reset();
		rst_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		chk("reset outs", 32'h1F, {27'h0, status_out, ~msg_ready, ~amp_oe, awake, &pin_level});
		rst_n <= 1'b1;
	endtask : do_reset

	task t_boot(input logic sa);
		int a;
		a = acc_cnt;
		host.send_pad(2);
		core_evt.init_done <= ~sa;
		wt(msg_ready, 1'b1, "boot ready", 0, sa ? 3 * MS + 4 : 2);
		wt(status_out, 1'b0, "boot idle", 0, 4);
		chk("pads dropped", a, acc_cnt);
		apb(1'b0, 8'h14, 32'h0);
		chk("pad count", 32'h2, rd);
		apb(1'b1, 8'h14, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk("pins enabled", {31'h0, sa}, {31'h0, rd[5]});
		$display("test boot done");
	endtask : t_boot
	task t_regs();
		apb(1'b0, 8'h04, 32'h0);
		chk("debounce", 32'h1, rd);
		apb(1'b0, 8'h08, 32'h0);
		chk("lead", 32'h1, rd);
		apb(1'b0, 8'h0C, 32'h0);
		chk("hold", 32'h1, rd);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h1, {rd[30:0], err});
		$display("test regs done");
	endtask : t_regs
	task t_pins();
		int e;
		e = ev_cnt;
		apb(1'b1, 8'h04, 32'h4);
		ctrl_pin[0] <= 1'b0;
		wt(lvl0, 1'b0, "pin fall", 3 * MS + 2, 5 * MS);
		ctrl_pin[0] <= 1'b1;
		wt(lvl0, 1'b1, "pin rise", 3 * MS + 2, 5 * MS);
		repeat (2) @(posedge core_clk);
		chk("pin events", e + 2, ev_cnt);
		$display("test pins done");
	endtask : t_pins
	task t_amp();
		int e;
		e = ev_cnt;
		pulse(0);
		ctrl_pin[1] <= 1'b0;
		@(posedge core_clk);
		chk("amp on", 32'h3, {30'h0, amp_en, amp_oe});
		wt(play_start, 1'b1, "amp lead", 10 * MS - 2, 11 * MS + 2);
		chk("lead pins", e, ev_cnt);
		ctrl_pin[1] <= 1'b1;
		n = 0;
		while (ev_cnt == e && n < 8 * MS) begin
			@(posedge core_clk);
			n++;
		end
		chk("pins after lead", e + 1, ev_cnt);
		pulse(1);
		repeat (4 * MS) @(posedge core_clk);
		chk("amp held", 32'h1, 32'(amp_en));
		pulse(0);
		wt(play_start, 1'b1, "no lead", 0, 3);
		pulse(1);
		wt(amp_en, 1'b0, "amp hold", 10 * MS - 2, 11 * MS + 4);
		chk("amp oe", 32'h1, 32'(amp_oe));
		$display("test amp done");
	endtask : t_amp
	task t_sleep(input logic sa);
		int nw[8] = '{50, 550, 40, 200, 0, 510, 0, 170};
		int t;
		for (int k = 0; k < 4; k++) begin
			t = nw[{sa, k[1:0]}];
			if (t != 0) begin
				apb(1'b1, 8'h00, {29'h0, k[1], 1'b0, sa});
				sleep_deep <= k[0];
				pulse(2);
				wt(awake, 1'b0, "asleep", 0, 4);
				if (sa) ctrl_pin[2] <= 1'b0;
				else pulse(3);
				wt(awake, 1'b1, "wake", 2 * t - 8, 2 * t + 8);
				ctrl_pin[2] <= 1'b1;
			end
		end
		$display("test sleep done");
	endtask : t_sleep
	task t_busy();
		for (int i = 1; i < 5; i++) begin
			@(posedge core_clk) core_evt <= core_evt_t'(5'h01 << i);
			wt(status_out, 1'b1, "busy", 0, 4);
			@(posedge core_clk) core_evt <= core_evt_t'(5'h00);
			wt(status_out, 1'b0, "idle", 0, 4);
		end
		$display("test busy done");
	endtask : t_busy
	task t_msg();
		int a;
		host.send_msg(1'b0, n);
		wt(msg_ready, 1'b0, "msg taken", 0, 2);
		a = acc_cnt;
		host.send_pad(2);
		wt(msg_ready, 1'b1, "msg gap", 0, 2008);
		chk("pad dropped", a, acc_cnt);
		host.send_pad(1);
		repeat (2) @(posedge core_clk);
		chk("byte taken", a + 1, acc_cnt);
		apb(1'b0, 8'h14, 32'h0);
		chk("pad count", 32'h2, rd);
		$display("test msg done");
	endtask : t_msg
	task t_play();
		pulse(0);
		wt(status_out, 1'b1, "play busy", 0, 4);
		wt(play_start, 1'b1, "play start", 0, 60 * MS);
		pulse(1);
		wt(status_out, 1'b0, "play end", 0, 6 * MS);
		$display("test play done");
	endtask : t_play
	// a request while frozen must leave no trace
	task t_freeze();
		clk_en <= 1'b0;
		pulse(0);
		repeat (3) @(posedge core_clk);
		chk("frozen", 32'h0, {30'h0, status_out, play_start});
		clk_en <= 1'b1;
		$display("test freeze done");
	endtask : t_freeze
	task t_ovr();
		host.send_msg(1'b1, n);
		wt(msg_ready, 1'b0, "ovr taken", 0, 2);
		repeat (2100) @(posedge core_clk);
		chk("ovr gap", 32'h0, 32'(msg_ready));
		$display("test overwrite done");
	endtask : t_ovr
	task t_flash();
		apb(1'b1, 8'h00, 32'h2);
		host.send_msg(1'b0, n);
		wt(status_out, 1'b1, "flash busy", 0, 140);
		flash_fail <= 1'b1;
		pulse(4);
		flash_fail <= 1'b0;
		wt(status_out, 1'b0, "flash end", 0, 4);
		wt(error_out, 1'b1, "flash error", 0, 80);
		apb(1'b1, 8'h00, 32'hA);
		@(posedge core_clk);
		chk("error clear", 32'h0, 32'(error_out));
		host.send_msg(1'b0, n);
		wt(status_out, 1'b1, "flash busy", 0, 140);
		wt(error_out, 1'b1, "flash timeout", 4 * MS, 5 * MS + 4);
		apb(1'b1, 8'h00, 32'h8);
		$display("test flash done");
	endtask : t_flash
	task results();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : results

	initial begin
		rst_n = 1'b0;
		{psel, penable, pwrite, play_req, play_done, flash_done, flash_fail} = 7'h00;
		{slp_req, sleep_deep, wake_req, clk_en} = 4'h1;
		paddr = 8'h00;
		pwdata = 32'h0;
		core_evt = core_evt_t'(5'h00);
		ctrl_pin = 4'hF;
		do_reset();
		// standalone is chosen before t_boot reads the pins-enabled bit
		apb(1'b1, 8'h00, 32'h1);
		t_boot(1'b1);
		t_regs();
		t_pins();
		t_amp();
		t_sleep(1'b1);
		do_reset();
		t_boot(1'b0);
		t_busy();
		t_msg();
		t_play();
		t_freeze();
		t_flash();
		t_sleep(1'b0);
		t_ovr();
		results();
	end
	// run needs about 10000 cycles; generous margin
	initial begin
		#600000;
		miscompares++;
		results();
	end
endmodule : playback_status_sequencer_tb_top
`default_nettype wire
